// file: logic/dopc_chan.v
// dopc_chan.v: one output channel, switch gating and overcurrent handling
// assumes fault inputs are synchronous to the core clock
`timescale 1ns/10ps

module dopc_chan (
    input wire core_clk_i,
    input wire nrst_i,
    input wire en_i,
    input wire supply_ok_i,       // supplies settled
    input wire data_valid_i,      // a valid word reached this channel
    input wire pu_set_i,          // host writes power-up one
    input wire pu_clr_i,          // host writes power-up zero
    input wire clamp_en_i,        // overcurrent response select
    input wire short_i,           // short circuit seen on the pin
    input wire therm_trip_i,      // thermal shutdown forcing
    output reg powerup_q,         // channel_powerup_bit
    output reg oc_q,              // overcurrent_flag
    output reg oc_rise_q,         // one-cycle pulse when flag sets
    output reg amp_isolation_gate_q,   // high: amplifier joined to pin
    output reg output_ground_switch_q, // high: pin clamped to ground
    output reg current_limit_q    // high: 20 mA clamp active
);

    // ***************************************************
    // combinational next values
    // ***************************************************
    reg pu_d;
    reg oc_d;
    reg live_d;

    // power-up bit and fault flag decisions
    always @* begin
        pu_d = powerup_q;
        oc_d = oc_q;
        if (pu_set_i) begin
            pu_d = 1'b1;
        end else if (pu_clr_i) begin
            pu_d = 1'b0;
        end
        if (clamp_en_i) begin
            oc_d = short_i;
        end else if (short_i && powerup_q) begin
            oc_d = 1'b1;
            pu_d = 1'b0;
        end else if (short_i) begin
            oc_d = 1'b1; // sticky in power-down mode until a power-up write after the short goes
        end else if (pu_set_i) begin
            oc_d = 1'b0; // host restart clears the old fault
        end
        if (therm_trip_i) begin
            pu_d = 1'b0;
        end
        // amplifier joins pin only when powered, supplies good and data valid
        live_d = pu_d && supply_ok_i && data_valid_i;
    end

    // ***************************************************
    // state registers
    // ***************************************************
    // all outputs held safe at reset: clamped and isolated
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            powerup_q <= 1'b0;
            oc_q <= 1'b0;
            oc_rise_q <= 1'b0;
            amp_isolation_gate_q <= 1'b0;
            output_ground_switch_q <= 1'b1;
            current_limit_q <= 1'b0;
        end else if (en_i) begin
            powerup_q <= pu_d;
            oc_q <= oc_d;
            oc_rise_q <= oc_d && !oc_q;
            amp_isolation_gate_q <= live_d;
            output_ground_switch_q <= !live_d;
            current_limit_q <= clamp_en_i && short_i && live_d;
        end
    end

endmodule // dopc_chan

// file: logic/dopc_defs.vh
// dopc_defs.vh: offsets, field positions and reset values of the output protection block
// assumes a plain register port with word-wide data and byte-less addressing
`ifndef DOPC_DEFS_VH
`define DOPC_DEFS_VH

// ***************************************************
// register offsets
// ***************************************************
`define DOPC_ADDR_W 4
`define DOPC_OFF_CTRL 4'h0
`define DOPC_OFF_PWR 4'h1
`define DOPC_OFF_IRQ_STAT 4'h2
`define DOPC_OFF_IRQ_MASK 4'h3
`define DOPC_OFF_DATA_A 4'h4
`define DOPC_OFF_DATA_B 4'h5
`define DOPC_OFF_STATE 4'h6

// ***************************************************
// control register fields
// ***************************************************
`define DOPC_CTRL_CLAMP_EN 2
`define DOPC_CTRL_TSD_ARM 3
`define DOPC_CTRL_RST 16'h0004

// ***************************************************
// power control register fields
// ***************************************************
`define DOPC_PWR_PU_A 0
`define DOPC_PWR_PU_B 2
`define DOPC_PWR_TALERT 5
`define DOPC_PWR_OC_A 7
`define DOPC_PWR_OC_B 9
`define DOPC_PWR_RST 16'h0000

// ***************************************************
// interrupt status fields
// ***************************************************
`define DOPC_IRQ_OC_A 0
`define DOPC_IRQ_OC_B 1
`define DOPC_IRQ_THERM 2
`define DOPC_IRQ_W 3
`define DOPC_IRQ_RST 3'h0

// ***************************************************
// timing
// ***************************************************
`define DOPC_SUPPLY_SETTLE_CYC 16

`endif

// file: logic/dopc_top.v
// dopc_top.v: dual channel output protection and power control
// assumes a synchronous register port, read data valid the cycle after a read strobe
//
// Summary of operation
// - outputs clamped and isolated during supply ramp
// - release only after stable supplies and data
// - each channel powers up or down alone
// - both channels start in power-down
// - powered-down channel grounded, amplifier disconnected
// - clamp enable selects overcurrent response
// - clamp mode limits current, sets flag
// - clamp mode flag clears when short ends
// - auto mode: power down shorted channel only
// - thermal shutdown disarmed until host arms
// - armed over-temperature powers down both channels
// - thermal event sets readable alert flag
// - alert and overcurrent flags read-only
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`include "dopc_defs.vh"

module dopc_top #(
    parameter DATA_W = 16,
    parameter SETTLE_CYC = `DOPC_SUPPLY_SETTLE_CYC
) (
    input wire core_clk_i,
    input wire nrst_i,
    input wire clk_en_i,
    input wire [`DOPC_ADDR_W-1:0] reg_addr_i,
    input wire [DATA_W-1:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire supply_ok_i,
    input wire short_a_i,
    input wire short_b_i,
    input wire over_temp_i,
    output reg [DATA_W-1:0] reg_rdata_o,
    output reg irq_o,
    output reg amp_isolation_gate_a_o,
    output reg amp_isolation_gate_b_o,
    output reg output_ground_switch_a_o,
    output reg output_ground_switch_b_o,
    output reg current_limit_a_o,
    output reg current_limit_b_o
);

    // ***************************************************
    // address decode helper
    // ***************************************************
    function hit;
        input [`DOPC_ADDR_W-1:0] addr;
        input [`DOPC_ADDR_W-1:0] off;
        begin
            hit = (addr == off);
        end
    endfunction

    // ***************************************************
    // declarations
    // ***************************************************
    reg [DATA_W-1:0] ctrl_q;           // control register
    reg [DATA_W-1:0] data_a_q;         // channel a data word
    reg [DATA_W-1:0] data_b_q;         // channel b data word
    reg valid_a_q;                     // a valid word written to a
    reg valid_b_q;                     // a valid word written to b
    reg talert_q;                      // thermal_alert_flag
    reg [`DOPC_IRQ_W-1:0] irq_stat_q;  // sticky events
    reg [`DOPC_IRQ_W-1:0] irq_mask_q;  // event enables
    reg [7:0] settle_q;                // supply settle counter
    reg supply_stable_q;               // supplies held good long enough
    reg [DATA_W-1:0] rdata_d;
    reg [`DOPC_IRQ_W-1:0] irq_stat_d;
    wire [1:0] pu_w;
    wire [1:0] oc_w;
    wire [1:0] oc_rise_w;
    wire [1:0] gate_w;
    wire [1:0] gnd_w;
    wire [1:0] lim_w;
    wire [1:0] short_w;
    wire [1:0] valid_w;
    wire wr_ctrl;
    wire wr_pwr;
    wire therm_trip;
    wire therm_event;
    wire [DATA_W-1:0] pwr_view;

    assign wr_ctrl = reg_wr_i && hit(reg_addr_i, `DOPC_OFF_CTRL);
    assign wr_pwr = reg_wr_i && hit(reg_addr_i, `DOPC_OFF_PWR);
    assign short_w = {short_b_i, short_a_i};
    assign valid_w = {valid_b_q, valid_a_q};
    // trip only while armed by the host
    assign therm_trip = over_temp_i && ctrl_q[`DOPC_CTRL_TSD_ARM];
    assign therm_event = therm_trip && !talert_q;

    // ***************************************************
    // supply settle tracking
    // ***************************************************
    // supplies count as stable after a run of good samples
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            settle_q <= 8'h00;
            supply_stable_q <= 1'b0;
        end else if (clk_en_i) begin
            if (!supply_ok_i) begin
                settle_q <= 8'h00; // brownout restarts the wait
                supply_stable_q <= 1'b0;
            end else if (settle_q == SETTLE_CYC[7:0]) begin
                supply_stable_q <= 1'b1;
            end else begin
                settle_q <= settle_q + 8'h01;
            end
        end
    end

    // ***************************************************
    // control, data and alert registers
    // ***************************************************
    // host writes; flags are not writable
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl_q <= `DOPC_CTRL_RST;
            data_a_q <= {DATA_W{1'b0}};
            data_b_q <= {DATA_W{1'b0}};
            valid_a_q <= 1'b0;
            valid_b_q <= 1'b0;
            talert_q <= 1'b0;
            irq_mask_q <= `DOPC_IRQ_RST;
        end else if (clk_en_i) begin
            if (wr_ctrl) begin
                ctrl_q <= reg_wdata_i;
            end
            if (reg_wr_i && hit(reg_addr_i, `DOPC_OFF_DATA_A)) begin
                data_a_q <= reg_wdata_i;
                valid_a_q <= 1'b1;
            end
            if (reg_wr_i && hit(reg_addr_i, `DOPC_OFF_DATA_B)) begin
                data_b_q <= reg_wdata_i;
                valid_b_q <= 1'b1;
            end
            if (reg_wr_i && hit(reg_addr_i, `DOPC_OFF_IRQ_MASK)) begin
                irq_mask_q <= reg_wdata_i[`DOPC_IRQ_W-1:0];
            end
            // alert stays until the condition leaves
            talert_q <= therm_trip;
            if (!supply_ok_i) begin
                valid_a_q <= 1'b0;
                valid_b_q <= 1'b0;
            end
        end
    end

    // ***************************************************
    // channels
    // ***************************************************
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
            // each channel has its own power-up bit position
            localparam integer PU_BIT = (gi == 0) ? `DOPC_PWR_PU_A : `DOPC_PWR_PU_B;
            dopc_chan u_chan (
                .core_clk_i(core_clk_i),
                .nrst_i(nrst_i),
                .en_i(clk_en_i),
                .supply_ok_i(supply_stable_q),
                .data_valid_i(valid_w[gi]),
                .pu_set_i(wr_pwr && reg_wdata_i[PU_BIT]),
                .pu_clr_i(wr_pwr && !reg_wdata_i[PU_BIT]),
                .clamp_en_i(ctrl_q[`DOPC_CTRL_CLAMP_EN]),
                .short_i(short_w[gi]),
                .therm_trip_i(therm_trip),
                .powerup_q(pu_w[gi]),
                .oc_q(oc_w[gi]),
                .oc_rise_q(oc_rise_w[gi]),
                .amp_isolation_gate_q(gate_w[gi]),
                .output_ground_switch_q(gnd_w[gi]),
                .current_limit_q(lim_w[gi])
            );
        end
    endgenerate

    // power control readback view
    assign pwr_view = ({{(DATA_W-1){1'b0}}, pu_w[0]} << `DOPC_PWR_PU_A)
                    | ({{(DATA_W-1){1'b0}}, pu_w[1]} << `DOPC_PWR_PU_B)
                    | ({{(DATA_W-1){1'b0}}, talert_q} << `DOPC_PWR_TALERT)
                    | ({{(DATA_W-1){1'b0}}, oc_w[0]} << `DOPC_PWR_OC_A)
                    | ({{(DATA_W-1){1'b0}}, oc_w[1]} << `DOPC_PWR_OC_B);

    // ***************************************************
    // interrupt status
    // ***************************************************
    // set wins over the read clear
    always @* begin
        irq_stat_d = irq_stat_q;
        if (reg_rd_i && hit(reg_addr_i, `DOPC_OFF_IRQ_STAT)) begin
            irq_stat_d = `DOPC_IRQ_RST;
        end
        if (oc_rise_w[0]) begin
            irq_stat_d[`DOPC_IRQ_OC_A] = 1'b1;
        end
        if (oc_rise_w[1]) begin
            irq_stat_d[`DOPC_IRQ_OC_B] = 1'b1;
        end
        if (therm_event) begin
            irq_stat_d[`DOPC_IRQ_THERM] = 1'b1;
        end
    end

    // status register and interrupt line
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_stat_q <= `DOPC_IRQ_RST;
            irq_o <= 1'b0;
        end else if (clk_en_i) begin
            irq_stat_q <= irq_stat_d;
            irq_o <= |(irq_stat_d & irq_mask_q);
        end
    end

    // ***************************************************
    // read port
    // ***************************************************
    // read mux, unmapped addresses return zero
    always @* begin
        rdata_d = {DATA_W{1'b0}};
        case (reg_addr_i)
            `DOPC_OFF_CTRL: rdata_d = ctrl_q;
            `DOPC_OFF_PWR: rdata_d = pwr_view;
            `DOPC_OFF_IRQ_STAT: rdata_d[`DOPC_IRQ_W-1:0] = irq_stat_q;
            `DOPC_OFF_IRQ_MASK: rdata_d[`DOPC_IRQ_W-1:0] = irq_mask_q;
            `DOPC_OFF_DATA_A: rdata_d = data_a_q;
            `DOPC_OFF_DATA_B: rdata_d = data_b_q;
            `DOPC_OFF_STATE: rdata_d[5:0] = {lim_w, gnd_w, gate_w};
            default: rdata_d = {DATA_W{1'b0}};
        endcase
    end

    // read data for exactly one cycle after the strobe
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= {DATA_W{1'b0}};
        end else if (clk_en_i) begin
            if (reg_rd_i) begin
                reg_rdata_o <= rdata_d;
            end else begin
                reg_rdata_o <= {DATA_W{1'b0}};
            end
        end
    end

    // ***************************************************
    // pin drive registers
    // ***************************************************
    // copies of channel switch state onto top outputs
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            amp_isolation_gate_a_o <= 1'b0;
            amp_isolation_gate_b_o <= 1'b0;
            output_ground_switch_a_o <= 1'b1;
            output_ground_switch_b_o <= 1'b1;
            current_limit_a_o <= 1'b0;
            current_limit_b_o <= 1'b0;
        end else if (clk_en_i) begin
            amp_isolation_gate_a_o <= gate_w[0];
            amp_isolation_gate_b_o <= gate_w[1];
            output_ground_switch_a_o <= gnd_w[0];
            output_ground_switch_b_o <= gnd_w[1];
            current_limit_a_o <= lim_w[0];
            current_limit_b_o <= lim_w[1];
        end
    end

endmodule // dopc_top

// file: testbench/dopc_host_model.sv
// dopc_host_model.sv: host controller on the register port
// assumes strobes are taken at the rising core clock edge
`timescale 1ns/10ps
`include "dopc_defs.vh"

module dopc_host_model (
    input wire core_clk_i,
    input wire [15:0] reg_rdata_i,
    output reg [3:0] reg_addr_o,
    output reg [15:0] reg_wdata_o,
    output reg reg_wr_o,
    output reg reg_rd_o
);
    // idle bus at time zero
    initial begin
        reg_addr_o = 4'h0;
        reg_wdata_o = 16'h0000;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
    end

    // one-cycle write, then scramble the released lines
    task wr(input [3:0] a, input [15:0] d);
        begin
            @(posedge core_clk_i);
            reg_addr_o <= a;
            reg_wdata_o <= d;
            reg_wr_o <= 1'b1;
            @(posedge core_clk_i);
            reg_wr_o <= 1'b0;
            reg_addr_o <= ~a;
            reg_wdata_o <= ~d;
        end
    endtask

    // one-cycle read, data taken in the following cycle
    task rd(input [3:0] a, output [15:0] d);
        begin
            @(posedge core_clk_i);
            reg_addr_o <= a;
            reg_rd_o <= 1'b1;
            @(posedge core_clk_i);
            reg_rd_o <= 1'b0;
            reg_addr_o <= ~a;
            #1 d = reg_rdata_i;
        end
    endtask

    // power a channel up, then hold off loading for 10 us
    task power_up(input [15:0] pu);
        begin
            wr(`DOPC_OFF_PWR, pu);
            repeat (1000) @(posedge core_clk_i);
        end
    endtask
endmodule // dopc_host_model

// file: testbench/dopc_properties.sv
// dopc_properties.sv: port checker for the output protection block, bound to dopc_top
// assumes the register map of dopc_defs.vh and clk_en_i held high
`timescale 1ns/10ps
`include "dopc_defs.vh"

module dopc_checker #(
    parameter DATA_W = 16,
    parameter SETTLE_CYC = 16
) (
    input wire core_clk_i,
    input wire nrst_i,
    input wire [`DOPC_ADDR_W-1:0] reg_addr_i,
    input wire [DATA_W-1:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire supply_ok_i,
    input wire short_a_i,
    input wire short_b_i,
    input wire over_temp_i,
    input wire [DATA_W-1:0] reg_rdata_o,
    input wire irq_o,
    input wire amp_isolation_gate_a_o,
    input wire amp_isolation_gate_b_o,
    input wire output_ground_switch_a_o,
    input wire output_ground_switch_b_o,
    input wire current_limit_a_o,
    input wire current_limit_b_o
);
    // ***************************************************
    // helper state shadowing supply, heat and the host's writes
    // ***************************************************
    reg [7:0] ok_cnt_q; // cycles of steady supply
    reg [1:0] hot_cnt_q; // cycles armed and hot
    reg arm_q; // shadow of thermal arm
    reg data_a_q; // channel a has seen a word
    reg [2:0] mask_q; // shadow of interrupt mask

    // track supply, heat and register writes
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ok_cnt_q <= 8'h00;
            hot_cnt_q <= 2'h0;
            arm_q <= 1'b0;
            data_a_q <= 1'b0;
            mask_q <= 3'h0;
        end else begin
            ok_cnt_q <= !supply_ok_i ? 8'h00 : ok_cnt_q + {7'h00, ok_cnt_q != 8'hff};
            hot_cnt_q <= (arm_q && over_temp_i) ? hot_cnt_q + {1'b0, hot_cnt_q != 2'h3} : 2'h0;
            if (reg_wr_i && reg_addr_i == `DOPC_OFF_CTRL) begin
                arm_q <= reg_wdata_i[`DOPC_CTRL_TSD_ARM];
            end
            if (reg_wr_i && reg_addr_i == `DOPC_OFF_DATA_A) begin
                data_a_q <= 1'b1;
            end else if (!supply_ok_i) begin
                data_a_q <= 1'b0; // supply drop forgets the word
            end
            if (reg_wr_i && reg_addr_i == `DOPC_OFF_IRQ_MASK) begin
                mask_q <= reg_wdata_i[2:0];
            end
        end
    end

    // ***************************************************
    // assertions
    // ***************************************************
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);

    chan_a_excl_a: assert property (!(amp_isolation_gate_a_o && output_ground_switch_a_o))
        else $error("channel a joined and grounded at once");
    chan_b_excl_a: assert property (!(amp_isolation_gate_b_o && output_ground_switch_b_o))
        else $error("channel b joined and grounded at once");
    supply_gate_a: assert property (amp_isolation_gate_a_o |-> $past(ok_cnt_q, 2) >= SETTLE_CYC)
        else $error("channel a joined before supplies settled");
    data_gate_a: assert property (amp_isolation_gate_a_o |-> $past(data_a_q, 2))
        else $error("channel a joined before a data word");
    limit_a_cause_a: assert property (current_limit_a_o |-> $past(short_a_i, 2))
        else $error("channel a limit without short");
    limit_b_cause_a: assert property (current_limit_b_o |-> $past(short_b_i, 2))
        else $error("channel b limit without short");
    therm_off_a: assert property (hot_cnt_q == 2'h3 |-> !amp_isolation_gate_a_o && !amp_isolation_gate_b_o)
        else $error("channels joined while armed and hot");
    rd_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == {DATA_W{1'b0}})
        else $error("read data outside the answer cycle");
    irq_mask_a: assert property (mask_q == 3'h0 && $past(mask_q) == 3'h0 |-> !irq_o)
        else $error("interrupt raised while all masked");

    // main scenarios reached
    cover property (amp_isolation_gate_a_o && amp_isolation_gate_b_o);
    cover property (current_limit_a_o);
    cover property (irq_o);
    cover property (hot_cnt_q == 2'h3);
endmodule // dopc_checker

bind dopc_top dopc_checker #(.DATA_W(DATA_W), .SETTLE_CYC(SETTLE_CYC)) chk_i (.core_clk_i(core_clk_i),
    .nrst_i(nrst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .supply_ok_i(supply_ok_i), .short_a_i(short_a_i), .short_b_i(short_b_i),
    .over_temp_i(over_temp_i), .reg_rdata_o(reg_rdata_o), .irq_o(irq_o),
    .amp_isolation_gate_a_o(amp_isolation_gate_a_o), .amp_isolation_gate_b_o(amp_isolation_gate_b_o),
    .output_ground_switch_a_o(output_ground_switch_a_o), .output_ground_switch_b_o(output_ground_switch_b_o),
    .current_limit_a_o(current_limit_a_o), .current_limit_b_o(current_limit_b_o));

// file: testbench/test_dopc_top.sv
// test_dopc_top.sv: self-checking bench for the output protection block
// assumes the host model and checker are compiled before it
`timescale 1ns/10ps
`include "dopc_defs.vh"

module test_dopc_top;
    reg core_clk_i = 1'b0;
    reg nrst_i = 1'b0;
    reg supply_ok_i = 1'b0;
    reg short_a_i = 1'b0;
    reg short_b_i = 1'b0;
    reg over_temp_i = 1'b0;
    reg clk_en = 1'b1; // clock enable, dropped once to freeze the block
    reg [15:0] lfsr_q = 16'h511c; // fixed seed
    wire [3:0] addr;
    wire [15:0] wdata;
    wire [15:0] rdata;
    wire wr;
    wire rd;
    wire irq_o;
    wire ga;
    wire gb;
    wire sa;
    wire sb;
    wire la;
    wire lb;
    integer miscompares = 0;
    integer check_count = 0;
    integer i;

    always #5 core_clk_i = ~core_clk_i; // 100 MHz

    dopc_top #(.SETTLE_CYC(2)) DUT (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .clk_en_i(clk_en),
        .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .supply_ok_i(supply_ok_i),
        .short_a_i(short_a_i), .short_b_i(short_b_i), .over_temp_i(over_temp_i), .reg_rdata_o(rdata),
        .irq_o(irq_o), .amp_isolation_gate_a_o(ga), .amp_isolation_gate_b_o(gb),
        .output_ground_switch_a_o(sa), .output_ground_switch_b_o(sb),
        .current_limit_a_o(la), .current_limit_b_o(lb));

    dopc_host_model host (.core_clk_i(core_clk_i), .reg_rdata_i(rdata), .reg_addr_o(addr),
        .reg_wdata_o(wdata), .reg_wr_o(wr), .reg_rd_o(rd));

    // expected power register view
    function [15:0] pwr_view(input pa, input pb, input ta, input oa, input ob);
        pwr_view = ({15'h0, pa} << `DOPC_PWR_PU_A) | ({15'h0, pb} << `DOPC_PWR_PU_B) |
            ({15'h0, ta} << `DOPC_PWR_TALERT) | ({15'h0, oa} << `DOPC_PWR_OC_A) | ({15'h0, ob} << `DOPC_PWR_OC_B);
    endfunction

    // next random word
    function [15:0] lfsr_next(input [15:0] s);
        lfsr_next = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    task chk(input [15:0] got, input [15:0] exp);
        begin
            check_count = check_count + 1;
            if (got !== exp) begin
                miscompares = miscompares + 1;
                $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            end
        end
    endtask

    task rchk(input [3:0] a, input [15:0] exp);
        reg [15:0] v;
        begin
            host.rd(a, v);
            chk(v, exp);
        end
    endtask

    // let the two-cycle pin path land
    task settle;
        begin
            repeat (3) @(posedge core_clk_i);
            #1;
        end
    endtask

    // gates a b, grounds a b
    task pins(input [3:0] exp);
        begin
            settle;
            chk({12'h0, ga, gb, sa, sb}, {12'h0, exp});
        end
    endtask

    task finish_test;
        begin
            if (miscompares == 0 && check_count > 0) begin
                $display("NO MISMATCHES");
            end else begin
                $display("MISMATCHES SEEN");
            end
            $finish;
        end
    endtask

    // watchdog
    initial begin
        #200000;
        miscompares = miscompares + 1;
        finish_test;
    end

    initial begin
        repeat (4) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        pins(4'b0011);
        rchk(`DOPC_OFF_CTRL, `DOPC_CTRL_RST);
        rchk(`DOPC_OFF_PWR, 16'h0000);
        rchk(4'hf, 16'h0000);
        @(posedge core_clk_i) supply_ok_i <= 1'b1;
        host.power_up(16'h0005);
        pins(4'b0011);
        lfsr_q = lfsr_next(lfsr_q);
        host.wr(`DOPC_OFF_DATA_A, lfsr_q);
        pins(4'b1001);
        host.wr(`DOPC_OFF_DATA_B, ~lfsr_q);
        pins(4'b1100);
        rchk(`DOPC_OFF_DATA_B, ~lfsr_q);
        host.wr(`DOPC_OFF_PWR, 16'h0001);
        pins(4'b1001);
        rchk(`DOPC_OFF_PWR, pwr_view(1, 0, 0, 0, 0));
        for (i = 0; i < 4; i = i + 1) begin
            lfsr_q = lfsr_next(lfsr_q);
            host.wr(`DOPC_OFF_PWR, (i == 0) ? 16'hffff : (lfsr_q | 16'h0005));
            rchk(`DOPC_OFF_PWR, pwr_view(1, 1, 0, 0, 0));
        end
        // frozen clock enable drops a power-down write
        @(posedge core_clk_i) clk_en <= 1'b0;
        host.wr(`DOPC_OFF_PWR, 16'h0000);
        @(posedge core_clk_i) clk_en <= 1'b1;
        rchk(`DOPC_OFF_PWR, pwr_view(1, 1, 0, 0, 0));
        // clamp mode short on a, unmasked
        host.wr(`DOPC_OFF_IRQ_MASK, 16'h0007);
        @(posedge core_clk_i) short_a_i <= 1'b1;
        settle;
        chk({14'h0, la, irq_o}, 16'h0003);
        rchk(`DOPC_OFF_PWR, pwr_view(1, 1, 0, 1, 0));
        rchk(`DOPC_OFF_IRQ_STAT, 16'h0001);
        rchk(`DOPC_OFF_IRQ_STAT, 16'h0000);
        rchk(`DOPC_OFF_STATE, 16'h0013);
        @(posedge core_clk_i) short_a_i <= 1'b0;
        settle;
        chk({14'h0, la, irq_o}, 16'h0000);
        rchk(`DOPC_OFF_PWR, pwr_view(1, 1, 0, 0, 0));
        // clamp mode short on b, masked
        host.wr(`DOPC_OFF_IRQ_MASK, 16'h0000);
        @(posedge core_clk_i) short_b_i <= 1'b1;
        settle;
        chk({14'h0, lb, irq_o}, 16'h0002);
        rchk(`DOPC_OFF_IRQ_STAT, 16'h0002);
        @(posedge core_clk_i) short_b_i <= 1'b0;
        // automatic power-down mode
        host.wr(`DOPC_OFF_CTRL, 16'h0000);
        @(posedge core_clk_i) short_b_i <= 1'b1;
        pins(4'b1001);
        rchk(`DOPC_OFF_PWR, pwr_view(1, 0, 0, 0, 1));
        @(posedge core_clk_i) short_b_i <= 1'b0;
        host.power_up(16'h0005);
        host.wr(`DOPC_OFF_DATA_B, lfsr_q);
        pins(4'b1100);
        rchk(`DOPC_OFF_PWR, pwr_view(1, 1, 0, 0, 0));
        // heat while disarmed, then armed
        @(posedge core_clk_i) over_temp_i <= 1'b1;
        pins(4'b1100);
        host.wr(`DOPC_OFF_CTRL, 16'h000c);
        pins(4'b0011);
        rchk(`DOPC_OFF_PWR, pwr_view(0, 0, 1, 0, 0));
        @(posedge core_clk_i) over_temp_i <= 1'b0;
        settle;
        rchk(`DOPC_OFF_PWR, 16'h0000);
        host.power_up(16'h0005);
        pins(4'b1100);
        // supply drop re-clamps both pins
        @(posedge core_clk_i) supply_ok_i <= 1'b0;
        pins(4'b0011);
        // second reset in mid-run
        @(posedge core_clk_i) nrst_i <= 1'b0;
        @(posedge core_clk_i) nrst_i <= 1'b1;
        pins(4'b0011);
        rchk(`DOPC_OFF_PWR, 16'h0000);
        finish_test;
    end
endmodule // test_dopc_top
